/* core/ssaf_pkg.sv */
package ssaf_pkg;

	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned SEC_NS        = 1_000_000_000;
	localparam int unsigned SEC_CYC_DEF   = SEC_NS / CLK_PERIOD_NS;
	localparam int unsigned MIN_S         = 60;

	localparam int unsigned MAC_W   = 48;
	localparam int unsigned PORT_W  = 5;
	localparam int unsigned STAMP_W = 12;
	localparam int unsigned HOLD_W  = 3;
	localparam int unsigned ALERT_W = 10;
	localparam int unsigned ANUM_W  = 2;

	localparam int unsigned HOLD_S         = 5;
	localparam int unsigned ALERT_FAST_S   = 5;
	localparam int unsigned ALERT_FAST_N   = 3;
	localparam int unsigned ALERT_SLOW_MIN = 15;
	localparam int unsigned ALERT_SLOW_S   = ALERT_SLOW_MIN * MIN_S;

	localparam logic [STAMP_W-1:0] AGE_DEF_MIN = 12'h005;
	localparam logic [STAMP_W-1:0] AGE_MAX_MIN = 12'he10;

	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_AGE    = 8'h04;
	localparam logic [7:0] REG_PSEC   = 8'h08;
	localparam logic [7:0] REG_PVMODE = 8'h0c;
	localparam logic [7:0] REG_PDIS   = 8'h10;
	localparam logic [7:0] REG_ELO    = 8'h14;
	localparam logic [7:0] REG_EHI    = 8'h18;
	localparam logic [7:0] REG_CMD    = 8'h1c;
	localparam logic [7:0] REG_STAT   = 8'h20;

	localparam int unsigned CTRL_SEC_BIT  = 0;
	localparam int unsigned CTRL_AGE_BIT  = 1;
	localparam int unsigned CTRL_ACT_LSB  = 2;
	localparam int unsigned EHI_PORT_LSB  = 16;
	localparam int unsigned CMD_ADD_BIT   = 0;
	localparam int unsigned CMD_DEL_BIT   = 1;
	localparam int unsigned STAT_BUSY_BIT = 0;
	localparam int unsigned STAT_FAIL_BIT = 1;
	localparam int unsigned STAT_CNT_LSB  = 16;

	typedef enum logic [1:0] {
		ACT_DROP           = 2'h0,
		ACT_DROP_NOTIFY    = 2'h1,
		ACT_DISABLE_NOTIFY = 2'h2
	} ssaf_act_e;

	typedef struct packed {
		logic               vld;
		logic [MAC_W-1:0]   mac;
		logic [PORT_W-1:0]  port;
		logic [STAMP_W-1:0] stamp;
	} ssaf_entry_s;

endpackage

/* core/ssaf_mem_if.sv */
`timescale 1ns/10ps
interface ssaf_mem_if import ssaf_pkg::*; #(
	parameter int unsigned AW = 10
) ();
	logic              rd_en;
	logic [AW-1:0]     rd_addr;
	ssaf_entry_s       rd_data;
	logic              wr_en;
	logic [AW-1:0]     wr_addr;
	ssaf_entry_s       wr_data;

	modport ctrl (output rd_en, rd_addr, wr_en, wr_addr, wr_data,
		input rd_data);
	modport mem (input rd_en, rd_addr, wr_en, wr_addr, wr_data,
		output rd_data);
endinterface

/* core/ssaf_mem.sv */
`timescale 1ns/10ps
module ssaf_mem import ssaf_pkg::*; #(
	parameter int unsigned DEPTH = 1024
) (
	input  wire logic  clk_sys_i,
	ssaf_mem_if.mem    m
);
	ssaf_entry_s ram [DEPTH];

	always_ff @(posedge clk_sys_i) begin
		if (m.wr_en) begin
			ram[m.wr_addr] <= m.wr_data;
		end
	end

	// read-during-write returns the old word; the controller never needs
	// the new one in the same cycle
	always_ff @(posedge clk_sys_i) begin
		if (m.rd_en) begin
			m.rd_data <= ram[m.rd_addr];
		end
	end
endmodule

/* core/ssaf_tick.sv */
`timescale 1ns/10ps
module ssaf_tick import ssaf_pkg::*; #(
	parameter int unsigned SEC_CYC = SEC_CYC_DEF
) (
	input  wire logic               clk_sys_i,
	input  wire logic               rst_i,
	output logic                    sec_tick_o,
	output logic                    min_tick_o,
	output logic [STAMP_W-1:0]      now_min_o
);
	localparam int unsigned CYC_W = $clog2(SEC_CYC);
	localparam int unsigned SEC_W = $clog2(MIN_S);

	logic [CYC_W-1:0] cyc;
	logic [SEC_W-1:0] secs;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			cyc        <= '0;
			sec_tick_o <= 1'b0;
		end else if (cyc == CYC_W'(SEC_CYC - 1)) begin
			cyc        <= '0;
			sec_tick_o <= 1'b1;
		end else begin
			cyc        <= cyc + 1'b1;
			sec_tick_o <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			secs       <= '0;
			min_tick_o <= 1'b0;
			now_min_o  <= '0;
		end else begin
			min_tick_o <= 1'b0;
			if (sec_tick_o) begin
				if (secs == SEC_W'(MIN_S - 1)) begin
					secs       <= '0;
					min_tick_o <= 1'b1;
					now_min_o  <= now_min_o + 1'b1;
				end else begin
					secs <= secs + 1'b1;
				end
			end
		end
	end
endmodule

/* core/ssaf_top.sv */
`timescale 1ns/10ps
// What this block does
// - secured port frames get their source address looked up first
// - reject when address missing or bound to another port only
// - tagged frame needs binding mode equal to its port's mode
// - plain drop action discards port traffic five seconds, no alert
// - drop-notify discards five seconds and raises an alert
// - disable-notify blocks port until software clears it, alerts
// - alerts five seconds apart thrice, then fifteen minutes apart
// - addresses learned before securing stay as secured entries
// - software adds and removes secured entries bound to a port
// - one address on several ports, at most 1024 entries
// - aging deletes entries idle longer than the aging interval
// - aging on/off; off after reset, on after config init
// - aging interval in minutes, default five, range one to 3600
// - interval zero means entries never age out
module ssaf_top import ssaf_pkg::*; #(
	parameter int unsigned NPORTS  = 24,
	parameter int unsigned DEPTH   = 1024,
	parameter int unsigned SEC_CYC = SEC_CYC_DEF
) (
	input  wire logic              clk_sys_i,
	input  wire logic              rst_i,
	input  wire logic [7:0]        paddr_i,
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [31:0]       pwdata_i,
	output logic [31:0]            prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	input  wire logic              nonvolatile_config_init_i,
	input  wire logic              frm_valid_i,
	output logic                   frm_ready_o,
	input  wire logic [PORT_W-1:0] frm_port_i,
	input  wire logic [MAC_W-1:0]  frm_source_address_i,
	input  wire logic              frm_tagged_i,
	input  wire logic              frm_vmode_i,
	output logic                   verdict_valid_o,
	output logic                   verdict_accept_o,
	output logic                   vio_o,
	output logic [PORT_W-1:0]      vio_port_o,
	output logic [MAC_W-1:0]       vio_source_address_o,
	output logic                   alert_o
);
	localparam int unsigned AW    = $clog2(DEPTH);
	localparam int unsigned CNT_W = $clog2(DEPTH + 1);

	typedef enum logic [4:0] {
		ST_INIT = 5'h01,
		ST_IDLE = 5'h02,
		ST_FCHK = 5'h04,
		ST_CCHK = 5'h08,
		ST_ACHK = 5'h10
	} ssaf_state_e;

	function automatic logic [AW-1:0] slot_of(
		input logic [MAC_W-1:0]  mac,
		input logic [PORT_W-1:0] port
	);
		logic [AW-1:0] h;
		h = '0;
		for (int i = 0; i < MAC_W; i++) begin
			h[i % AW] = h[i % AW] ^ mac[i];
		end
		for (int i = 0; i < PORT_W; i++) begin
			h[(i * 3) % AW] = h[(i * 3) % AW] ^ port[i];
		end
		return h;
	endfunction

	ssaf_mem_if #(.AW(AW)) mif ();

	ssaf_mem #(.DEPTH(DEPTH)) u_mem (
		.clk_sys_i (clk_sys_i),
		.m         (mif.mem)
	);

	logic               sec_tick;
	logic               min_tick;
	logic [STAMP_W-1:0] now_min;

	ssaf_tick #(.SEC_CYC(SEC_CYC)) u_tick (
		.clk_sys_i  (clk_sys_i),
		.rst_i      (rst_i),
		.sec_tick_o (sec_tick),
		.min_tick_o (min_tick),
		.now_min_o  (now_min)
	);

	ssaf_state_e        state;
	ssaf_state_e        next_state;
	logic               sec_mode;
	logic               age_en;
	ssaf_act_e          act;
	logic [STAMP_W-1:0] age_time;
	logic [NPORTS-1:0]  port_sec;
	logic [NPORTS-1:0]  port_vmode;
	logic [NPORTS-1:0]  port_dis;
	logic [MAC_W-1:0]   ent_mac;
	logic [PORT_W-1:0]  ent_port;
	logic               cmd_pend;
	logic               cmd_add;
	logic               cmd_fail;
	logic [CNT_W-1:0]   ent_cnt;
	logic               age_pend;
	logic [AW-1:0]      scan_idx;
	logic [MAC_W-1:0]   f_mac;
	logic [PORT_W-1:0]  f_port;
	logic               f_tag;
	logic               f_vm;
	logic [HOLD_W-1:0]  hold   [NPORTS];
	logic [ALERT_W-1:0] atmr   [NPORTS];
	logic [ANUM_W-1:0]  anum   [NPORTS];
	logic               seen   [NPORTS];

	ssaf_entry_s e;
	logic        f_hit;
	logic        f_ok;
	logic        f_sec;
	logic        f_blk;
	logic        f_vio;
	logic        f_acc;
	logic        c_hit;
	logic        aged;
	logic        take_frm;
	logic        take_cmd;
	logic        take_age;
	logic        wr_acc;
	logic        wr_reg;
	logic        rd_setup;
	logic        addr_ok;

	assign e     = mif.rd_data;
	assign f_ok  = f_port < PORT_W'(NPORTS);
	assign f_hit = e.vld && e.mac == f_mac && e.port == f_port;
	assign f_sec = f_ok && sec_mode && port_sec[f_port];
	assign f_blk = !f_ok || port_dis[f_port] || hold[f_port] != '0;
	assign f_vio = state == ST_FCHK && f_sec && !f_blk && !f_hit;
	// frames on unsecured ports pass unless held or disabled; secured ones need a binding match
	assign f_acc = !f_blk && (!f_sec || (f_hit &&
		!(f_tag && f_vm != port_vmode[f_port])));
	assign c_hit = e.vld && e.mac == ent_mac && e.port == ent_port;
	assign aged  = e.vld && age_time != '0 &&
		STAMP_W'(now_min - e.stamp) > age_time;

	assign take_frm = state == ST_IDLE && frm_valid_i;
	assign take_cmd = state == ST_IDLE && !frm_valid_i && cmd_pend;
	assign take_age = state == ST_IDLE && !frm_valid_i && !cmd_pend &&
		age_pend;
	assign frm_ready_o = state == ST_IDLE;

	always_comb begin
		next_state = state;
		case (state)
			ST_INIT: if (scan_idx == AW'(DEPTH - 1)) next_state = ST_IDLE;
			ST_IDLE: begin
				if (take_frm) next_state = ST_FCHK;
				else if (take_cmd) next_state = ST_CCHK;
				else if (take_age) next_state = ST_ACHK;
			end
			ST_FCHK: next_state = ST_IDLE;
			ST_CCHK: next_state = ST_IDLE;
			ST_ACHK: next_state = ST_IDLE;
			default: next_state = ST_INIT;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) state <= ST_INIT;
		else state <= next_state;
	end

	always_comb begin
		mif.rd_en   = take_frm || take_cmd || take_age;
		mif.rd_addr = take_frm ? slot_of(frm_source_address_i, frm_port_i) :
			take_cmd ? slot_of(ent_mac, ent_port) : scan_idx;
		mif.wr_en   = 1'b0;
		mif.wr_addr = '0;
		mif.wr_data = '0;
		case (state)
			ST_INIT: begin
				mif.wr_en   = 1'b1;
				mif.wr_addr = scan_idx;
			end
			ST_FCHK: begin
				// unsecured ports keep learning so that securing later
				// finds the addresses already in place
				mif.wr_en   = f_acc && (f_hit || (!f_sec && !e.vld));
				mif.wr_addr = slot_of(f_mac, f_port);
				mif.wr_data = '{1'b1, f_mac, f_port, now_min};
			end
			ST_CCHK: begin
				mif.wr_addr = slot_of(ent_mac, ent_port);
				mif.wr_en   = cmd_add ? (!e.vld || c_hit) : c_hit;
				mif.wr_data = cmd_add ?
					'{1'b1, ent_mac, ent_port, now_min} : '0;
			end
			ST_ACHK: begin
				mif.wr_en   = aged;
				mif.wr_addr = scan_idx;
			end
			default: begin
				mif.wr_en = 1'b0;
			end
		endcase
	end

	// entry count: a slot is only filled when empty, so depth bounds it
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			ent_cnt <= '0;
		end else if (mif.wr_en && state != ST_INIT) begin
			if (mif.wr_data.vld && !e.vld) ent_cnt <= ent_cnt + 1'b1;
			else if (!mif.wr_data.vld && e.vld) ent_cnt <= ent_cnt - 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			scan_idx <= '0;
			age_pend <= 1'b0;
		end else begin
			if (state == ST_INIT || state == ST_ACHK) begin
				scan_idx <= scan_idx + 1'b1;
			end
			if (min_tick && age_en && age_time != '0) begin
				age_pend <= 1'b1;
			end else if (state == ST_ACHK &&
				scan_idx == AW'(DEPTH - 1)) begin
				age_pend <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (take_frm) begin
			f_mac  <= frm_source_address_i;
			f_port <= frm_port_i;
			f_tag  <= frm_tagged_i;
			f_vm   <= frm_vmode_i;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			verdict_valid_o      <= 1'b0;
			verdict_accept_o     <= 1'b0;
			vio_o                <= 1'b0;
			vio_port_o           <= '0;
			vio_source_address_o <= '0;
		end else begin
			verdict_valid_o  <= state == ST_FCHK;
			verdict_accept_o <= state == ST_FCHK && f_acc;
			vio_o            <= f_vio;
			if (f_vio) begin
				vio_port_o           <= f_port;
				vio_source_address_o <= f_mac;
			end
		end
	end

	// per-port hold, disable and alert pacing; an attempt while the
	// port is held still counts as the intrusion persisting
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			alert_o <= 1'b0;
			for (int p = 0; p < NPORTS; p++) begin
				hold[p]     <= '0;
				atmr[p]     <= '0;
				anum[p]     <= '0;
				seen[p]     <= 1'b0;
				port_dis[p] <= 1'b0;
			end
		end else begin
			alert_o <= 1'b0;
			for (int p = 0; p < NPORTS; p++) begin
				if (wr_reg && paddr_i == REG_PDIS && pwdata_i[p]) begin
					port_dis[p] <= 1'b0;
				end
				if (sec_tick && hold[p] != '0) hold[p] <= hold[p] - 1'b1;
				if (sec_tick && atmr[p] != '0) begin
					atmr[p] <= atmr[p] - 1'b1;
					if (atmr[p] == ALERT_W'(1)) begin
						seen[p] <= 1'b0;
						if (!seen[p]) anum[p] <= '0;
					end
				end
				if (state == ST_FCHK && f_sec && !f_acc &&
					f_port == PORT_W'(p)) begin
					seen[p] <= 1'b1;
				end
				if (f_vio && f_port == PORT_W'(p)) begin
					if (act == ACT_DISABLE_NOTIFY) port_dis[p] <= 1'b1;
					else hold[p] <= HOLD_W'(HOLD_S + 1);
					if (act != ACT_DROP && atmr[p] == '0) begin
						alert_o <= 1'b1;
						if (anum[p] != ANUM_W'(ALERT_FAST_N)) begin
							anum[p] <= anum[p] + 1'b1;
						end
						atmr[p] <= (anum[p] >= ANUM_W'(ALERT_FAST_N - 1)) ?
							ALERT_W'(ALERT_SLOW_S + 1) :
							ALERT_W'(ALERT_FAST_S + 1);
					end
				end
			end
		end
	end

	assign pready_o  = 1'b1;
	assign wr_acc    = psel_i && penable_i;
	assign wr_reg    = wr_acc && pwrite_i && addr_ok;
	assign rd_setup  = psel_i && !penable_i && !pwrite_i;
	assign addr_ok   = paddr_i inside {REG_CTRL, REG_AGE, REG_PSEC,
		REG_PVMODE, REG_PDIS, REG_ELO, REG_EHI, REG_CMD, REG_STAT};
	assign pslverr_o = wr_acc && !addr_ok;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			sec_mode   <= 1'b0;
			age_en     <= 1'b0;
			act        <= ACT_DROP;
			age_time   <= AGE_DEF_MIN;
			port_sec   <= '0;
			port_vmode <= '0;
			ent_mac    <= '0;
			ent_port   <= '0;
		end else if (nonvolatile_config_init_i) begin
			age_en   <= 1'b1;
			age_time <= AGE_DEF_MIN;
		end else if (wr_reg) begin
			case (paddr_i)
				REG_CTRL: begin
					sec_mode <= pwdata_i[CTRL_SEC_BIT];
					age_en   <= pwdata_i[CTRL_AGE_BIT];
					act      <= ssaf_act_e'(pwdata_i[CTRL_ACT_LSB +: 2]);
				end
				REG_AGE: age_time <= (pwdata_i > 32'(AGE_MAX_MIN)) ?
					AGE_MAX_MIN : pwdata_i[STAMP_W-1:0];
				REG_PSEC: port_sec <= pwdata_i[NPORTS-1:0];
				REG_PVMODE: port_vmode <= pwdata_i[NPORTS-1:0];
				REG_ELO: ent_mac[31:0] <= pwdata_i;
				REG_EHI: begin
					ent_mac[MAC_W-1:32] <= pwdata_i[MAC_W-33:0];
					ent_port <= pwdata_i[EHI_PORT_LSB +: PORT_W];
				end
				default: ;
			endcase
		end
	end

	// a command written while one is pending is ignored
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			cmd_pend <= 1'b0;
			cmd_add  <= 1'b0;
			cmd_fail <= 1'b0;
		end else if (state == ST_CCHK) begin
			cmd_pend <= 1'b0;
			cmd_fail <= !mif.wr_en;
		end else if (wr_reg && paddr_i == REG_CMD && !cmd_pend &&
			(pwdata_i[CMD_ADD_BIT] || pwdata_i[CMD_DEL_BIT])) begin
			cmd_pend <= 1'b1;
			cmd_add  <= pwdata_i[CMD_ADD_BIT];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			prdata_o <= '0;
		end else if (rd_setup) begin
			case (paddr_i)
				REG_CTRL: prdata_o <= 32'({act, age_en, sec_mode});
				REG_AGE: prdata_o <= 32'(age_time);
				REG_PSEC: prdata_o <= 32'(port_sec);
				REG_PVMODE: prdata_o <= 32'(port_vmode);
				REG_PDIS: prdata_o <= 32'(port_dis);
				REG_ELO: prdata_o <= ent_mac[31:0];
				REG_EHI: prdata_o <= 32'({ent_port, ent_mac[MAC_W-1:32]});
				REG_STAT: prdata_o <= (32'(ent_cnt) << STAT_CNT_LSB) |
					(32'(cmd_fail) << STAT_FAIL_BIT) |
					(32'(cmd_pend || state == ST_INIT) << STAT_BUSY_BIT);
				default: prdata_o <= '0;
			endcase
		end
	end
endmodule

/* dv/ssaf_frame_src.sv */
`timescale 1ns/10ps
// ingress pipeline: offers one frame per request and holds it until taken
module ssaf_frame_src import ssaf_pkg::*; (
	input  wire logic              clk_sys_i,
	input  wire logic              go_i,
	input  wire logic [PORT_W-1:0] port_i,
	input  wire logic [MAC_W-1:0]  mac_i,
	input  wire logic              tag_i,
	input  wire logic              vmode_i,
	input  wire logic              frm_ready_i,
	output logic                   frm_valid_o,
	output logic [PORT_W-1:0]      frm_port_o,
	output logic [MAC_W-1:0]       frm_source_address_o,
	output logic                   frm_tagged_o,
	output logic                   frm_vmode_o
);
	initial begin
		frm_valid_o          = 1'b0;
		frm_port_o           = '0;
		frm_source_address_o = '0;
		frm_tagged_o         = 1'b0;
		frm_vmode_o          = 1'b0;
	end
	// fields flip every idle cycle so a late sample cannot match by luck
	always @(posedge clk_sys_i) begin
		if (go_i && !frm_valid_o) begin
			frm_valid_o          <= 1'b1;
			frm_port_o           <= port_i;
			frm_source_address_o <= mac_i;
			frm_tagged_o         <= tag_i;
			frm_vmode_o          <= vmode_i;
		end else if (!frm_valid_o || frm_ready_i) begin
			frm_valid_o          <= 1'b0;
			frm_port_o           <= ~frm_port_o;
			frm_source_address_o <= ~frm_source_address_o;
			frm_tagged_o         <= ~frm_tagged_o;
			frm_vmode_o          <= ~frm_vmode_o;
		end
	end
endmodule

/* dv/ssaf_top_monitor.sv */
`timescale 1ns/10ps
module ssaf_top_monitor import ssaf_pkg::*; #(
	parameter int unsigned SEC_CYC = SEC_CYC_DEF
) (
	input  wire logic              clk_sys_i,
	input  wire logic              rst_i,
	input  wire logic              frm_valid_i,
	input  wire logic              frm_ready_o,
	input  wire logic [PORT_W-1:0] frm_port_i,
	input  wire logic [MAC_W-1:0]  frm_source_address_i,
	input  wire logic              verdict_valid_o,
	input  wire logic              verdict_accept_o,
	input  wire logic              vio_o,
	input  wire logic [PORT_W-1:0] vio_port_o,
	input  wire logic [MAC_W-1:0]  vio_source_address_o,
	input  wire logic              alert_o
);
	localparam int unsigned GAP = ALERT_FAST_S * SEC_CYC;
	logic              take;
	int unsigned       since;
	logic [PORT_W-1:0] last_port;
	assign take = frm_valid_i && frm_ready_o;
	// pacing is per port, so only back-to-back alerts of one port are timed
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			since <= GAP;
		end else if (alert_o) begin
			since <= 0;
		end else if (since < GAP) begin
			since <= since + 1;
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			last_port <= '0;
		end else if (alert_o) begin
			last_port <= vio_port_o;
		end
	end
	a_verdict_lat: assert property (@(posedge clk_sys_i)
		disable iff (rst_i) take |-> ##2 verdict_valid_o)
		else $error("verdict missing two cycles after take");
	a_verdict_cause: assert property (@(posedge clk_sys_i)
		disable iff (rst_i) verdict_valid_o |-> $past(take, 2))
		else $error("verdict without a taken frame");
	a_take_gap: assert property (@(posedge clk_sys_i)
		disable iff (rst_i) take |=> !frm_ready_o)
		else $error("ready during lookup");
	a_vio_rejects: assert property (@(posedge clk_sys_i)
		disable iff (rst_i) vio_o |-> verdict_valid_o && !verdict_accept_o)
		else $error("violation on an accepted frame");
	a_vio_fields: assert property (@(posedge clk_sys_i)
		disable iff (rst_i) vio_o |-> vio_port_o == $past(frm_port_i, 2)
		&& vio_source_address_o == $past(frm_source_address_i, 2))
		else $error("violation fields wrong");
	a_vio_pulse: assert property (@(posedge clk_sys_i)
		disable iff (rst_i) vio_o |=> !vio_o)
		else $error("violation longer than one cycle");
	a_alert_cause: assert property (@(posedge clk_sys_i)
		disable iff (rst_i) alert_o |-> vio_o)
		else $error("alert without violation");
	a_alert_space: assert property (@(posedge clk_sys_i)
		disable iff (rst_i)
		alert_o && vio_port_o == last_port |-> since >= GAP - 1)
		else $error("alerts of one port too close");
endmodule
bind ssaf_top ssaf_top_monitor #(.SEC_CYC(SEC_CYC)) u_mon (
	.clk_sys_i            (clk_sys_i),
	.rst_i                (rst_i),
	.frm_valid_i          (frm_valid_i),
	.frm_ready_o          (frm_ready_o),
	.frm_port_i           (frm_port_i),
	.frm_source_address_i (frm_source_address_i),
	.verdict_valid_o      (verdict_valid_o),
	.verdict_accept_o     (verdict_accept_o),
	.vio_o                (vio_o),
	.vio_port_o           (vio_port_o),
	.vio_source_address_o (vio_source_address_o),
	.alert_o              (alert_o)
);

/* dv/ssaf_top_bench.sv */
`timescale 1ns/10ps
module ssaf_top_bench import ssaf_pkg::*;;
	localparam int unsigned      SC    = 10;
	localparam int               LIMIT = 12000;
	localparam logic [MAC_W-1:0] MA    = 48'h0200000000a1;
	localparam logic [MAC_W-1:0] MB    = 48'h0200000000b2;
	localparam logic [MAC_W-1:0] ML    = 48'h0200000000c3;
	logic              clk_sys_i = 1'b0, rst_i = 1'b1, nvi = 1'b0;
	logic [7:0]        paddr = '0;
	logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0]       pwdata = '0, prdata, r;
	logic              pready, pslverr, e;
	logic              go = 1'b0, g_tag = 1'b0, g_vm = 1'b0;
	logic [PORT_W-1:0] g_port = '0, frm_port, vio_port;
	logic [MAC_W-1:0]  g_mac = '0, frm_mac, vio_mac, rm;
	logic              frm_valid, frm_ready, frm_tagged, frm_vmode;
	logic              verdict_valid, verdict_accept, vio, alert;
	int                n_mismatch = 0, tests_run = 0, cyc = 0, seed = 90;
	int                act = 0, hold_until [32], acnt [32];
	bit                tbl [bit [52:0]];
	bit [31:0]         psec = '0, pvmode = '0, pdis = '0;

	ssaf_top #(.NPORTS(24), .DEPTH(1024), .SEC_CYC(SC)) u_dut (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .paddr_i(paddr),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .nonvolatile_config_init_i(nvi),
		.frm_valid_i(frm_valid), .frm_ready_o(frm_ready),
		.frm_port_i(frm_port), .frm_source_address_i(frm_mac),
		.frm_tagged_i(frm_tagged), .frm_vmode_i(frm_vmode),
		.verdict_valid_o(verdict_valid), .verdict_accept_o(verdict_accept),
		.vio_o(vio), .vio_port_o(vio_port), .vio_source_address_o(vio_mac),
		.alert_o(alert));
	ssaf_frame_src u_src (
		.clk_sys_i(clk_sys_i), .go_i(go), .port_i(g_port), .mac_i(g_mac),
		.tag_i(g_tag), .vmode_i(g_vm), .frm_ready_i(frm_ready),
		.frm_valid_o(frm_valid), .frm_port_o(frm_port),
		.frm_source_address_o(frm_mac), .frm_tagged_o(frm_tagged),
		.frm_vmode_o(frm_vmode));

	always #4 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == LIMIT) begin
			n_mismatch++;
			summarize();
		end
	end

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [47:0] seen,
			input logic [47:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask
	task automatic apb(input logic [7:0] a, input logic w,
			input logic [31:0] d);
		int n;
		@(posedge clk_sys_i);
		psel    <= 1'b1;
		penable <= 1'b0;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		@(posedge clk_sys_i);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (pready !== 1'b1 && n < 50);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) n_mismatch++;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask
	task automatic rd(input logic [7:0] a);
		apb(a, 1'b0, 32'h0);
	endtask
	// op 1 adds, op 2 removes; entry registers must be written first
	task automatic cmd(input int p, input logic [MAC_W-1:0] m, input int op);
		int n;
		wr(REG_ELO, m[31:0]);
		wr(REG_EHI, {11'h000, 5'(p), m[47:32]});
		wr(REG_CMD, 32'(op));
		n = 0;
		do begin
			rd(REG_STAT);
			n++;
		end while (r[STAT_BUSY_BIT] !== 1'b0 && n < 50);
		if (n >= 50) n_mismatch++;
		if (op == 1) tbl[{5'(p), m}] = 1;
		else tbl.delete({5'(p), m});
		check("stat fail", r[STAT_FAIL_BIT], 0);
		check("entry count", r[26:16], tbl.num());
	endtask
	task automatic frame(input int p, input logic [MAC_W-1:0] m,
			input logic t, input logic v);
		int n;
		bit ok, xv, xa;
		bit [52:0] k;
		k = {5'(p), m};
		ok = 1;
		xv = 0;
		xa = 0;
		if (psec[p] && (pdis[p] || cyc < hold_until[p])) begin
			ok = 0;
		end else if (psec[p] && !tbl.exists(k)) begin
			ok = 0;
			xv = 1;
			xa = act != 0 && acnt[p] < 3;
		end else if (psec[p] && t && v != pvmode[p]) begin
			ok = 0;
		end else if (!psec[p]) begin
			tbl[k] = 1;
		end
		@(posedge clk_sys_i);
		go     <= 1'b1;
		g_port <= 5'(p);
		g_mac  <= m;
		g_tag  <= t;
		g_vm   <= v;
		@(posedge clk_sys_i);
		go <= 1'b0;
		n = 0;
		do begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end while (verdict_valid !== 1'b1 && n < 20);
		if (n >= 20) n_mismatch++;
		check("accept", verdict_accept, ok);
		check("violation", vio, xv);
		check("alert", alert, xa);
		if (xv) begin
			check("vio port", vio_port, p);
			check("vio addr", vio_mac, m);
			if (act == 2) pdis[p] = 1;
			// hold is five to six s by tick phase; take is 3 cycles on
			else hold_until[p] = cyc + (HOLD_S + 1) * SC - 3;
		end
		if (xa) acnt[p]++;
	endtask

	initial begin
		int n;
		repeat (6) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		rd(REG_CTRL);
		check("ctrl reset", r, 0);
		rd(REG_AGE);
		check("age reset", r, AGE_DEF_MIN);
		rd(8'h40);
		check("unmapped err", e, 1);
		check("unmapped data", r, 0);
		@(posedge clk_sys_i);
		nvi <= 1'b1;
		@(posedge clk_sys_i);
		nvi <= 1'b0;
		rd(REG_CTRL);
		check("ctrl init", r[CTRL_AGE_BIT], 1);
		wr(REG_AGE, 32'h00000fa0);
		rd(REG_AGE);
		check("age clamp", r, AGE_MAX_MIN);
		wr(REG_AGE, 32'h00000000);
		$display("test registers done");
		n = 0;
		while (frm_ready !== 1'b1 && n < 1200) begin
			@(posedge clk_sys_i);
			n++;
		end
		if (n >= 1200) n_mismatch++;
		act = 1;
		wr(REG_CTRL, 32'h00000007);
		frame(3, ML, 1'b0, 1'b0);
		cmd(1, MA, 1);
		cmd(2, MA, 1);
		psec = 32'h0000007e;
		pvmode = 32'h00000004;
		wr(REG_PSEC, psec);
		wr(REG_PVMODE, pvmode);
		frame(3, ML, 1'b0, 1'b0);
		frame(1, MA, 1'b0, 1'b0);
		frame(2, MA, 1'b1, 1'b0);
		frame(2, MA, 1'b1, 1'b1);
		frame(1, MB, 1'b0, 1'b0);
		frame(1, MA, 1'b0, 1'b0);
		idle(60);
		frame(1, MA, 1'b0, 1'b0);
		frame(4, MA, 1'b0, 1'b0);
		$display("test secure done");
		act = 0;
		wr(REG_CTRL, 32'h00000003);
		frame(5, MB, 1'b0, 1'b0);
		act = 2;
		wr(REG_CTRL, 32'h0000000b);
		frame(3, MB, 1'b0, 1'b0);
		idle(60);
		frame(3, ML, 1'b0, 1'b0);
		rd(REG_PDIS);
		check("disabled", r, pdis);
		wr(REG_PDIS, 32'h00000008);
		pdis = '0;
		frame(3, ML, 1'b0, 1'b0);
		act = 1;
		wr(REG_CTRL, 32'h00000007);
		cmd(1, MA, 2);
		frame(1, MA, 1'b0, 1'b0);
		$display("test actions done");
		// steady intruder traffic: only the first three violations alert
		repeat (12) begin
			frame(6, MB, 1'b0, 1'b0);
			idle(27);
		end
		$display("test pacing done");
		repeat (8) begin
			rm = {16'($random(seed)), 32'($random(seed))};
			frame(7 * ($random(seed) & 1), rm, 1'($random(seed)),
				1'($random(seed)));
		end
		frame(3, ML, 1'b0, 1'b0);
		idle(3 * MIN_S * SC);
		frame(3, ML, 1'b0, 1'b0);
		wr(REG_AGE, 32'h00000001);
		// expiry may take two minutes, then a sweep of two cycles a slot
		idle(6 * MIN_S * SC);
		tbl.delete();
		frame(3, ML, 1'b0, 1'b0);
		$display("test aging done");
		summarize();
	end
endmodule
